/* include/mcr_pkg.sv */
// Package of constants and types for the motor configuration register bank.
package mcr_pkg;

  localparam int CLK_PERIOD_NS = 10;

  localparam logic [7:0] ALGO_OFFSET = 8'h58;
  localparam logic [7:0] PIN_OFFSET = 8'h5C;
  localparam logic [7:0] GATE_OFFSET = 8'h60;
  localparam logic [7:0] STATUS_OFFSET = 8'h64;

  localparam logic [31:0] ALGO_RESET = 32'h0000_0000;
  localparam logic [31:0] PIN_RESET = 32'h0000_0000;
  localparam logic [31:0] GATE_RESET = 32'h0000_0000;

  localparam logic [31:0] ALGO_WMASK = 32'h0000_03C3;
  localparam logic [31:0] PIN_WMASK = 32'h0008_0007;
  localparam logic [31:0] GATE_WMASK = 32'h0000_7E00;

  localparam int ACCEL_LSB = 6;
  localparam int HOLD_LSB = 0;
  localparam int FILT_OFF_BIT = 19;
  localparam int BRAKE_MODE_BIT = 2;
  localparam int BRAKE_SRC_LSB = 0;
  localparam int DEAD_LSB = 9;

  localparam int STAT_LOWSIDE_BIT = 0;
  localparam int STAT_ALIGN_BIT = 1;
  localparam int STAT_SETTLED_BIT = 2;
  localparam int STAT_BYPASS_BIT = 3;

  localparam int DEAD_UNIT_NS = 50;
  localparam int DEAD_UNIT_CYC = (DEAD_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int HOLD0_MS = 50;
  localparam int HOLD1_MS = 100;
  localparam int HOLD2_MS = 250;
  localparam int HOLD3_MS = 500;
  localparam int HOLD0_CYC = HOLD0_MS * (1000000 / CLK_PERIOD_NS);
  localparam int HOLD1_CYC = HOLD1_MS * (1000000 / CLK_PERIOD_NS);
  localparam int HOLD2_CYC = HOLD2_MS * (1000000 / CLK_PERIOD_NS);
  localparam int HOLD3_CYC = HOLD3_MS * (1000000 / CLK_PERIOD_NS);

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    BRK_PIN_A,
    BRK_FORCE_ON,
    BRK_FORCE_OFF,
    BRK_PIN_B
  } mcr_brake_src_e;

  // Decoded settings handed from the register file to the control logic.
  typedef struct packed {
    logic [3:0] accelCode;
    logic [1:0] holdCode;
    logic filterOff;
    logic alignMode;
    logic [1:0] brakeSrc;
    logic [5:0] deadCode;
  } mcr_cfg_s;

  // Slow acceleration in units of 0.1 Hz/s.
  function automatic logic [15:0] accelRate(input logic [3:0] code);
    case (code)
      4'h0: accelRate = 16'h0001;
      4'h1: accelRate = 16'h000A;
      4'h2: accelRate = 16'h0014;
      4'h3: accelRate = 16'h001E;
      4'h4: accelRate = 16'h0032;
      4'h5: accelRate = 16'h0064;
      4'h6: accelRate = 16'h00C8;
      4'h7: accelRate = 16'h012C;
      4'h8: accelRate = 16'h0190;
      4'h9: accelRate = 16'h01F4;
      4'hA: accelRate = 16'h03E8;
      4'hB: accelRate = 16'h07D0;
      4'hC: accelRate = 16'h1388;
      4'hD: accelRate = 16'h1D4C;
      4'hE: accelRate = 16'h2710;
      default: accelRate = 16'h4E20;
    endcase
  endfunction

endpackage

/* core/mcr_dead_time.sv */
// One phase of gate drive with break-before-make dead time.
`timescale 1ns/1ps
`default_nettype none
module mcr_dead_time
  import mcr_pkg::*;
#(
  parameter int CNT_W = 9
) (
  // Clock and control
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  // Phase request and dead time in clock cycles
  input wire logic highReq,
  input wire logic [CNT_W-1:0] deadCycles,
  // Gate drive
  output logic gateHigh_q,
  output logic gateLow_q
);

  logic applied_q;
  logic [CNT_W-1:0] cnt_q;

  // Both switches go off on any change of request, and the new side comes on only after
  // the dead time; at least one off cycle is always kept so the two never overlap.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      applied_q <= 1'b0;
      cnt_q <= '0;
      gateHigh_q <= 1'b0;
      gateLow_q <= 1'b0;
    end else if (ce) begin
      if (highReq != applied_q) begin
        applied_q <= highReq;
        cnt_q <= deadCycles;
        gateHigh_q <= 1'b0;
        gateLow_q <= 1'b0;
      end else if (cnt_q > CNT_W'(1)) begin
        cnt_q <= cnt_q - CNT_W'(1);
      end else begin
        cnt_q <= '0;
        gateHigh_q <= applied_q;
        gateLow_q <= ~applied_q;
      end
    end
  end

endmodule
`default_nettype wire

/* core/mcr_config_regs.sv */
// Motor configuration register bank with AHB-Lite access, brake, filter and dead time.
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module mcr_config_regs
  import mcr_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int VDC_W = 12,
  parameter int FILT_SHIFT = 3,
  parameter int PHASES = 3,
  parameter int unsigned HOLD0_CYCLES = HOLD0_CYC,
  parameter int unsigned HOLD1_CYCLES = HOLD1_CYC,
  parameter int unsigned HOLD2_CYCLES = HOLD2_CYC,
  parameter int unsigned HOLD3_CYCLES = HOLD3_CYC
) (
  // Clock, reset and enable
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Brake and current sensing
  input wire logic brakePin,
  input wire logic brakeCurrentLow,
  output logic brakeLowSide_q,
  output logic brakeAlign_q,
  output logic brakeCurrentSettled_q,
  // Bus voltage measurement
  input wire logic [VDC_W-1:0] busVoltIn,
  input wire logic busVoltValid,
  output logic [VDC_W-1:0] busVoltOut_q,
  output logic busVoltOutValid_q,
  // Algorithm setting
  output logic [15:0] slowAccelRate_q,
  // Gate drive
  input wire logic [PHASES-1:0] pwmHighReq,
  output logic [PHASES-1:0] gateHigh,
  output logic [PHASES-1:0] gateLow
);

  localparam int CNT_W = 9;
  localparam int HOLD_W = 30;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave

  logic [31:0] algo_q;
  logic [31:0] pin_q;
  logic [31:0] gate_q;
  logic [31:0] algo_d;
  logic [31:0] pin_d;
  logic [31:0] gate_d;
  logic wrPend_q;
  logic [ADDR_W-1:0] wrAddr_q;
  logic addrTaken;
  logic [31:0] statusWord;
  mcr_cfg_s cfg;

  assign addrTaken = hsel && hready && htrans == HTRANS_NONSEQ;

  // Returns a register with the write data merged into its writable bits only.
  function automatic logic [31:0] merge(input logic [31:0] cur, input logic [31:0] wd,
                                        input logic [31:0] mask);
    merge = (cur & ~mask) | (wd & mask);
  endfunction

  // A write lands at the end of its data phase; reads look at the next values so a read
  // right behind a write to the same register sees the new contents.
  always_comb begin
    algo_d = algo_q;
    pin_d = pin_q;
    gate_d = gate_q;
    if (wrPend_q) begin
      case (wrAddr_q)
        ADDR_W'(ALGO_OFFSET): algo_d = merge(algo_q, hwdata, ALGO_WMASK);
        ADDR_W'(PIN_OFFSET): pin_d = merge(pin_q, hwdata, PIN_WMASK);
        ADDR_W'(GATE_OFFSET): gate_d = merge(gate_q, hwdata, GATE_WMASK);
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= '0;
    end else if (ce) begin
      wrPend_q <= addrTaken && hwrite;
      wrAddr_q <= haddr;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      algo_q <= ALGO_RESET;
      pin_q <= PIN_RESET;
      gate_q <= GATE_RESET;
    end else if (ce) begin
      algo_q <= algo_d;
      pin_q <= pin_d;
      gate_q <= gate_d;
    end
  end

  always_comb begin
    statusWord = '0;
    statusWord[STAT_LOWSIDE_BIT] = brakeLowSide_q;
    statusWord[STAT_ALIGN_BIT] = brakeAlign_q;
    statusWord[STAT_SETTLED_BIT] = brakeCurrentSettled_q;
    statusWord[STAT_BYPASS_BIT] = cfg.filterOff;
  end

  // Zero wait states, so read data is registered at the end of the address phase.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addrTaken && !hwrite) begin
        case (haddr)
          ADDR_W'(ALGO_OFFSET): hrdata <= algo_d & ALGO_WMASK;
          ADDR_W'(PIN_OFFSET): hrdata <= pin_d & PIN_WMASK;
          ADDR_W'(GATE_OFFSET): hrdata <= gate_d & GATE_WMASK;
          ADDR_W'(STATUS_OFFSET): hrdata <= statusWord;
          default: hrdata <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Field decode

  always_comb begin
    cfg.accelCode = algo_q[ACCEL_LSB +: 4];
    cfg.holdCode = algo_q[HOLD_LSB +: 2];
    cfg.filterOff = pin_q[FILT_OFF_BIT];
    cfg.alignMode = pin_q[BRAKE_MODE_BIT];
    cfg.brakeSrc = pin_q[BRAKE_SRC_LSB +: 2];
    cfg.deadCode = gate_q[DEAD_LSB +: 6];
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      slowAccelRate_q <= '0;
    end else if (ce) begin
      slowAccelRate_q <= accelRate(cfg.accelCode);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Brake request

  logic brakeReq;

  always_comb begin
    case (mcr_brake_src_e'(cfg.brakeSrc))
      BRK_FORCE_ON: brakeReq = 1'b1;
      BRK_FORCE_OFF: brakeReq = 1'b0;
      default: brakeReq = brakePin;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      brakeLowSide_q <= 1'b0;
      brakeAlign_q <= 1'b0;
    end else if (ce) begin
      brakeLowSide_q <= brakeReq && !cfg.alignMode;
      brakeAlign_q <= brakeReq && cfg.alignMode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Brake current persistence

  logic [HOLD_W-1:0] holdCnt_q;
  logic [HOLD_W-1:0] holdTarget;

  always_comb begin
    case (cfg.holdCode)
      2'h0: holdTarget = HOLD_W'(HOLD0_CYCLES);
      2'h1: holdTarget = HOLD_W'(HOLD1_CYCLES);
      2'h2: holdTarget = HOLD_W'(HOLD2_CYCLES);
      default: holdTarget = HOLD_W'(HOLD3_CYCLES);
    endcase
  end

  // The count only runs while a brake is applied; any rise of current restarts it.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      holdCnt_q <= '0;
      brakeCurrentSettled_q <= 1'b0;
    end else if (ce) begin
      if (!(brakeLowSide_q || brakeAlign_q) || !brakeCurrentLow) begin
        holdCnt_q <= '0;
        brakeCurrentSettled_q <= 1'b0;
      end else if (holdCnt_q + HOLD_W'(1) >= holdTarget) begin
        brakeCurrentSettled_q <= 1'b1;
      end else begin
        holdCnt_q <= holdCnt_q + HOLD_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus voltage filter

  logic [VDC_W-1:0] filt_q;
  logic signed [VDC_W:0] filtDiff;
  logic [VDC_W-1:0] filtNext;

  // A first-order low pass; the shift trades settling time against ripple.
  always_comb begin
    filtDiff = $signed({1'b0, busVoltIn}) - $signed({1'b0, filt_q});
    filtNext = filt_q + VDC_W'(filtDiff >>> FILT_SHIFT);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      filt_q <= '0;
      busVoltOut_q <= '0;
      busVoltOutValid_q <= 1'b0;
    end else if (ce) begin
      busVoltOutValid_q <= busVoltValid;
      if (busVoltValid) begin
        filt_q <= filtNext;
        busVoltOut_q <= cfg.filterOff ? busVoltIn : filtNext;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Gate drive

  logic [CNT_W-1:0] deadCycles;
  logic [PHASES-1:0] phaseReq;

  assign deadCycles = CNT_W'(cfg.deadCode) * CNT_W'(DEAD_UNIT_CYC);

  // Braking overrides the modulator: all phases low, or phase 0 high for alignment.
  always_comb begin
    phaseReq = pwmHighReq;
    if (brakeLowSide_q) begin
      phaseReq = '0;
    end else if (brakeAlign_q) begin
      phaseReq = PHASES'(1);
    end
  end

  for (genvar p = 0; p < PHASES; p++) begin : gPhase
    mcr_dead_time #(
      .CNT_W(CNT_W)
    ) uDead (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .ce(ce),
      .highReq(phaseReq[p]),
      .deadCycles(deadCycles),
      .gateHigh_q(gateHigh[p]),
      .gateLow_q(gateLow[p])
    );
  end

  logic unusedSize;
  assign unusedSize = ^hsize;

endmodule
`default_nettype wire

/* verif/mcr_config_regs_asserts.sv */
// Checker bound to the motor configuration register bank ports.
`timescale 1ns/1ps
`default_nettype none
module mcr_config_regs_asserts
  import mcr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Bus
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Brake, filter and gates
  input wire logic brakeCurrentLow,
  input wire logic brakeLowSide_q,
  input wire logic brakeAlign_q,
  input wire logic brakeCurrentSettled_q,
  input wire logic busVoltValid,
  input wire logic busVoltOutValid_q,
  input wire logic [2:0] gateHigh,
  input wire logic [2:0] gateLow
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic rdTaken;
  assign rdTaken = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
  ////////////////////////////////////////////////////////////////////////////
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or not okay");
  property p_resv; rdTaken |=> (hrdata & ~(ALGO_WMASK | PIN_WMASK | GATE_WMASK | 32'hF)) == 32'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits read nonzero");
  property p_unmap; rdTaken && haddr == 8'h70 |=> hrdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  property p_hold; !rdTaken |=> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  property p_rst; $fell(sys_rst) |-> hrdata == 32'h0 && !brakeLowSide_q && !brakeAlign_q;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_excl; !(brakeLowSide_q && brakeAlign_q); endproperty
  a_excl: assert property (p_excl) else $error("both brake kinds active");
  property p_lowside; brakeLowSide_q [*3] |-> gateHigh == 3'h0; endproperty
  a_lowside: assert property (p_lowside) else $error("high side on in low-side brake");
  property p_align; brakeAlign_q [*3] |-> gateHigh[2:1] == 2'h0 && !gateLow[0]; endproperty
  a_align: assert property (p_align) else $error("align brake drive wrong");
  property p_settle;
    brakeCurrentSettled_q |-> $past(brakeCurrentLow) && $past(brakeLowSide_q || brakeAlign_q);
  endproperty
  a_settle: assert property (p_settle) else $error("settled without low current");
  property p_cross; (gateHigh & gateLow) == 3'h0; endproperty
  a_cross: assert property (p_cross) else $error("both gates of a phase on");
  property p_dead; $fell(gateLow[0]) || $fell(gateHigh[0]) |-> gateLow[0] == gateHigh[0];
  endproperty
  a_dead: assert property (p_dead) else $error("no dead time on phase 0");
  property p_vld; busVoltValid |=> busVoltOutValid_q; endproperty
  a_vld: assert property (p_vld) else $error("sample not passed on");
  property p_vld2; busVoltOutValid_q |-> $past(busVoltValid); endproperty
  a_vld2: assert property (p_vld2) else $error("output valid without a sample");
  c_low: cover property (brakeLowSide_q);
  c_align: cover property (brakeAlign_q);
  c_settle: cover property ($rose(brakeCurrentSettled_q));
endmodule
bind mcr_config_regs mcr_config_regs_asserts u_chk (.mclk, .sys_rst, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hreadyout, .hresp, .hrdata, .brakeCurrentLow, .brakeLowSide_q,
  .brakeAlign_q, .brakeCurrentSettled_q, .busVoltValid, .busVoltOutValid_q, .gateHigh, .gateLow);
`default_nettype wire

/* verif/mcr_power_stage.sv */
// Power stage model that reports when the brake current has decayed.
`timescale 1ns/1ps
`default_nettype none
module mcr_power_stage (
  // Clock
  input wire logic mclk,
  // Gate drive
  input wire logic [2:0] gateHigh,
  input wire logic [2:0] gateLow,
  // Sensed current
  output logic brakeCurrentLow
);
  logic [7:0] phaseCurrent_q;
  // Current decays only while every low side conducts; any other drive recharges it.
  always_ff @(posedge mclk) begin
    if (gateLow != 3'h7 || gateHigh != 3'h0) begin
      phaseCurrent_q <= 8'h10;
    end else if (phaseCurrent_q != 8'h0) begin
      phaseCurrent_q <= phaseCurrent_q - 8'h1;
    end
  end
  assign brakeCurrentLow = phaseCurrent_q == 8'h0;
endmodule
`default_nettype wire

/* verif/mcr_config_regs_test.sv */
// Self-checking bench for the motor configuration register bank.
`timescale 1ns/1ps
`default_nettype none
module mcr_config_regs_test import mcr_pkg::*;;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, brakePin = 1'b0, busVoltValid = 1'b0;
  logic [7:0] haddr = 8'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [11:0] busVoltIn = 12'h0;
  logic [2:0] pwmHighReq = 3'h0;
  wire logic hreadyout, hresp, brakeCurrentLow, brakeLowSide_q, brakeAlign_q;
  wire logic brakeCurrentSettled_q, busVoltOutValid_q;
  wire logic [31:0] hrdata;
  wire logic [11:0] busVoltOut_q;
  wire logic [15:0] slowAccelRate_q;
  wire logic [2:0] gateHigh, gateLow;
  int miscompares = 0;
  int compares = 0;
  int holdCyc [4] = '{32'h14, 32'h28, 32'h64, 32'hC8};
  logic [15:0] accTab [16] = '{16'h1, 16'hA, 16'h14, 16'h1E, 16'h32, 16'h64, 16'hC8, 16'h12C,
    16'h190, 16'h1F4, 16'h3E8, 16'h7D0, 16'h1388, 16'h1D4C, 16'h2710, 16'h4E20};
  always #5 mclk = ~mclk;
  mcr_config_regs #(.HOLD0_CYCLES(20), .HOLD1_CYCLES(40), .HOLD2_CYCLES(100),
    .HOLD3_CYCLES(200)) dut (.mclk, .sys_rst, .ce, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .brakePin,
    .brakeCurrentLow, .brakeLowSide_q, .brakeAlign_q, .brakeCurrentSettled_q, .busVoltIn,
    .busVoltValid, .busVoltOut_q, .busVoltOutValid_q, .slowAccelRate_q, .pwmHighReq,
    .gateHigh, .gateLow);
  mcr_power_stage stage (.mclk, .gateHigh, .gateLow, .brakeCurrentLow);
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic chk_win(input string name, input int lo, input int hi, input int g);
    compares++;
    if (g < lo || g > hi) begin
      miscompares++;
      $display("[FAIL] %s expected %0d to %0d seen %0d", name, lo, hi, g);
    end
  endtask
  // A wait that runs out of its bound ends the run as a failure.
  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      miscompares++;
      give_verdict();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    for (int p = 0; p < 2; p++) begin
      n = 0;
      do begin
        @(posedge mclk);
        n++;
      end while (hreadyout !== 1'b1 && n < 20);
      guard(n, hreadyout === 1'b1 ? 21 : 20);
      htrans <= 2'h0;
      hwdata <= d;
    end
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(name, e, r);
  endtask
  task automatic sample(input logic [11:0] v, input logic [11:0] e);
    @(posedge mclk);
    busVoltIn <= v;
    busVoltValid <= 1'b1;
    @(posedge mclk);
    busVoltValid <= 1'b0;
    @(posedge mclk);
    chk("bus voltage", e, busVoltOut_q);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    rdchk("algo reset", 8'h58, 32'h0);
    rdchk("pin reset", 8'h5C, 32'h0);
    rdchk("gate reset", 8'h60, 32'h0);
    chk("rate after reset", accTab[0], slowAccelRate_q);
    $display("test_reset done");
  endtask
  task automatic test_masks();
    logic [7:0] offs [3] = '{8'h58, 8'h5C, 8'h60};
    logic [31:0] msk [3] = '{32'h3C3, 32'h80007, 32'h7E00};
    foreach (offs[i]) begin
      wr(offs[i], 32'hFFFF_FFFF);
      rdchk("writable bits", offs[i], msk[i]);
      wr(offs[i], 32'h0);
    end
    wr(8'h70, 32'hFFFF_FFFF);
    rdchk("unmapped", 8'h70, 32'h0);
    $display("test_masks done");
  endtask
  task automatic test_accel();
    for (int c = 0; c < 16; c++) begin
      wr(8'h58, c << 6);
      repeat (2) @(posedge mclk);
      chk("accel rate", accTab[c], slowAccelRate_q);
    end
    $display("test_accel done");
  endtask
  task automatic test_filter();
    sample(12'h800, 12'h100);
    sample(12'h900, 12'h200);
    wr(8'h5C, 32'h8_0002);
    sample(12'hABC, 12'hABC);
    wr(8'h5C, 32'h2);
    $display("test_filter done");
  endtask
  task automatic test_brake();
    for (int k = 0; k < 16; k++) begin
      logic m, p, q;
      logic [1:0] s;
      {m, s, p} = k[3:0];
      q = s == 2'h1 || (s != 2'h2 && p);
      brakePin <= p;
      wr(8'h5C, {m, s});
      repeat (3) @(posedge mclk);
      chk("low-side brake", q && !m, brakeLowSide_q);
      chk("align brake", q && m, brakeAlign_q);
    end
    brakePin <= 1'b0;
    $display("test_brake done");
  endtask
  task automatic test_hold();
    int n;
    pwmHighReq <= 3'h7;
    for (int h = 0; h < 4; h++) begin
      wr(8'h5C, 32'h2);
      wr(8'h58, h);
      repeat (30) @(posedge mclk);
      wr(8'h5C, 32'h1);
      for (n = 0; brakeCurrentLow !== 1'b1 && n < 200; n++) @(posedge mclk);
      guard(n, 200);
      for (n = 0; brakeCurrentSettled_q !== 1'b1 && n < 400; n++) @(posedge mclk);
      chk_win("hold cycles", holdCyc[h] - 1, holdCyc[h] + 2, n);
      // Low-side brake and settled both show in the status word while the current stays low.
      rdchk("status word", 8'h64, 32'h5);
      wr(8'h5C, 32'h2);
      repeat (3) @(posedge mclk);
      chk("settled cleared", 32'h0, brakeCurrentSettled_q);
    end
    $display("test_hold done");
  endtask
  task automatic test_dead();
    int n;
    int codes [3] = '{0, 2, 63};
    foreach (codes[i]) begin
      pwmHighReq <= 3'h0;
      wr(8'h60, codes[i] << 9);
      repeat (330) @(posedge mclk);
      pwmHighReq <= 3'h7;
      for (n = 0; gateLow[0] !== 1'b0 && n < 10; n++) @(posedge mclk);
      guard(n, 10);
      for (n = 0; gateHigh[0] !== 1'b1 && n < 400; n++) @(posedge mclk);
      chk_win("dead cycles", codes[i] ? codes[i] * 5 : 1, codes[i] * 5 + 1, n);
    end
    $display("test_dead done");
  endtask
  // With the enable low a change of request must not reach the gates until it returns.
  task automatic test_ce();
    ce <= 1'b0;
    pwmHighReq <= 3'h0;
    repeat (8) @(posedge mclk);
    chk("frozen high gates", 32'h7, gateHigh);
    chk("frozen low gates", 32'h0, gateLow);
    ce <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("released high gates", 32'h0, gateHigh);
    $display("test_ce done");
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    test_reset();
    test_masks();
    test_accel();
    test_filter();
    test_brake();
    test_hold();
    test_dead();
    test_ce();
    give_verdict();
  end
endmodule
`default_nettype wire
